// [verilog/rsa_defs.svh]
// offsets, field positions, reset values and sizes of the register set
`ifndef RSA_DEFS_SVH
`define RSA_DEFS_SVH
`define RSA_WORD_W 16
`define RSA_PHYS_W 20
`define RSA_SEG_SHIFT 4
`define RSA_NUM_GPR 8
`define RSA_NUM_SEG 4
`define RSA_CMD_W 12
`define RSA_OFF_FETCH 8'h20
`define RSA_OFF_FLAGS 8'h24
`define RSA_OFF_CMD 8'h40
`define RSA_OFF_DISP 8'h44
`define RSA_OFF_PHYS 8'h48
`define RSA_GPR_PFX 3'h0
`define RSA_SEG_PFX 4'h3
`define RSA_BYTE_PFX 3'h3
`define RSA_GPR_ACC 3'h0
`define RSA_GPR_COUNT 3'h1
`define RSA_GPR_BASE 3'h3
`define RSA_GPR_STACK 3'h4
`define RSA_GPR_FRAME 3'h5
`define RSA_GPR_SRC 3'h6
`define RSA_GPR_DEST 3'h7
`define RSA_SEG_CS 2'h0
`define RSA_SEG_SS 2'h1
`define RSA_SEG_DS 2'h2
`define RSA_SEG_ES 2'h3
`define RSA_RST_WORD 16'h0000
`define RSA_RST_PHYS 20'h0_0000
`define RSA_RST_DATA 32'h0000_0000
`define RSA_STEP_BYTE 16'h0001
`define RSA_STEP_WORD 16'h0002
`endif

// [verilog/rsa_pkg.sv]
// types shared by the register set and address generator
package rsa_pkg;
	typedef logic [15:0] rsa_word_t;
	typedef logic [19:0] rsa_phys_t;
	// reference type picks the segment base
	typedef enum logic [1:0] {
		RSA_REF_FETCH,
		RSA_REF_STACK,
		RSA_REF_DATA,
		RSA_REF_EXTRA
	} rsa_ref_e;
	// address generation command, written as one word
	typedef struct packed {
		logic wordStep;
		logic countDown;
		logic stepDown;
		logic stepDest;
		logic stepSource;
		logic useDisp;
		logic indexIsDest;
		logic useIndex;
		logic baseIsFrame;
		logic useBase;
		rsa_ref_e kind;
	} rsa_cmd_s;
	// flag update from the execution unit
	typedef struct packed {
		logic load;
		rsa_word_t value;
	} rsa_flag_upd_s;
endpackage : rsa_pkg

// [verilog/rsa_register_set.sv]
// register set with segmented physical address generator on Avalon-MM
`timescale 1ns/1ps
`include "rsa_defs.svh"

module rsa_register_set (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Avalon-MM slave
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// execution unit flag update
	input wire rsa_pkg::rsa_flag_upd_s flagUpd,
	// generated physical address
	output rsa_pkg::rsa_phys_t physAddr,
	output logic physValid
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	// register storage
	rsa_pkg::rsa_word_t gpr [0:`RSA_NUM_GPR-1];
	rsa_pkg::rsa_word_t segBase [0:`RSA_NUM_SEG-1];
	rsa_pkg::rsa_word_t fetchPointer;
	rsa_pkg::rsa_word_t flags;
	rsa_pkg::rsa_word_t dispReg;

	function automatic rsa_pkg::rsa_phys_t phys_of(input rsa_pkg::rsa_word_t seg,
		input rsa_pkg::rsa_word_t off);
		phys_of = {seg, 4'h0} + {4'h0, off};
	endfunction : phys_of

	function automatic rsa_pkg::rsa_word_t merge(input rsa_pkg::rsa_word_t old,
		input logic [15:0] data, input logic [1:0] be);
		merge = {be[1] ? data[15:8] : old[15:8], be[0] ? data[7:0] : old[7:0]};
	endfunction : merge

	function automatic rsa_pkg::rsa_word_t step(input rsa_pkg::rsa_word_t v,
		input logic down, input logic wide);
		logic [15:0] amt;
		amt = wide ? `RSA_STEP_WORD : `RSA_STEP_BYTE;
		step = down ? v - amt : v + amt;
	endfunction : step

	// bus handshake
	wire busReq = read | write;
	wire wrAcc = write & ~waitrequest;
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			waitrequest <= 1'b1;
		end else begin
			waitrequest <= ~(busReq & waitrequest);
		end
	end

	// address decode
	wire alignOk = address[1:0] == 2'h0;
	wire gprHit = alignOk & (address[7:5] == `RSA_GPR_PFX);
	wire segHit = alignOk & (address[7:4] == `RSA_SEG_PFX);
	wire byteHit = alignOk & (address[7:5] == `RSA_BYTE_PFX);
	wire fetchHit = address == `RSA_OFF_FETCH;
	wire flagHit = address == `RSA_OFF_FLAGS;
	wire cmdHit = address == `RSA_OFF_CMD;
	wire dispHit = address == `RSA_OFF_DISP;
	wire physHit = address == `RSA_OFF_PHYS;
	wire [2:0] gprSel = address[4:2];
	wire [1:0] segSelBus = address[3:2];
	wire [1:0] byteReg = address[3:2];
	wire byteHigh = address[4];
	wire [15:0] byteWord = gpr[{1'b0, byteReg}];
	wire [7:0] byteRead = byteHigh ? byteWord[15:8] : byteWord[7:0];

	// read mux; unmapped reads return zero
	wire [31:0] rdMux =
		gprHit ? {16'h0000, gpr[gprSel]} :
		segHit ? {16'h0000, segBase[segSelBus]} :
		byteHit ? {24'h00_0000, byteRead} :
		fetchHit ? {16'h0000, fetchPointer} :
		flagHit ? {16'h0000, flags} :
		dispHit ? {16'h0000, dispReg} :
		physHit ? {12'h000, physAddr} :
		`RSA_RST_DATA;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			readdata <= `RSA_RST_DATA;
		end else if (busReq & waitrequest) begin
			readdata <= read ? rdMux : readdata;
		end
	end

	// address generation command
	wire cmdWr = wrAcc & cmdHit;
	rsa_pkg::rsa_cmd_s cmd;
	assign cmd = rsa_pkg::rsa_cmd_s'(writedata[`RSA_CMD_W-1:0]);
	wire [15:0] baseVal = cmd.baseIsFrame ? gpr[`RSA_GPR_FRAME] : gpr[`RSA_GPR_BASE];
	wire [15:0] indexVal = cmd.indexIsDest ? gpr[`RSA_GPR_DEST] : gpr[`RSA_GPR_SRC];
	wire [15:0] effAddr = (cmd.useDisp ? dispReg : 16'h0000)
		+ (cmd.useBase ? baseVal : 16'h0000)
		+ (cmd.useIndex ? indexVal : 16'h0000);
	wire isFetch = cmd.kind == rsa_pkg::RSA_REF_FETCH;
	wire isStack = cmd.kind == rsa_pkg::RSA_REF_STACK;
	wire isExtra = cmd.kind == rsa_pkg::RSA_REF_EXTRA;
	wire [1:0] segPick = isFetch ? `RSA_SEG_CS : isStack ? `RSA_SEG_SS :
		isExtra ? `RSA_SEG_ES : `RSA_SEG_DS;
	wire [15:0] logicalAddr = isFetch ? fetchPointer : isStack ? gpr[`RSA_GPR_STACK] : effAddr;
	wire [19:0] next_physAddr = phys_of(segBase[segPick], logicalAddr);

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			physAddr <= `RSA_RST_PHYS;
			physValid <= 1'b0;
		end else begin
			physAddr <= cmdWr ? next_physAddr : physAddr;
			physValid <= cmdWr;
		end
	end

	// general registers: bus writes, byte writes and command side effects
	wire [1:0] wordBe = byteenable[1:0];
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < `RSA_NUM_GPR; i++) begin
				gpr[i] <= `RSA_RST_WORD;
			end
		end else begin
			for (int i = 0; i < `RSA_NUM_GPR; i++) begin
				if (wrAcc & gprHit & (gprSel == 3'(i))) begin
					gpr[i] <= merge(gpr[i], writedata[15:0], wordBe);
				end else if (wrAcc & byteHit & byteenable[0] & (i < 4) & (byteReg == 2'(i))) begin
					gpr[i] <= merge(gpr[i], {2{writedata[7:0]}}, {byteHigh, ~byteHigh});
				end else if (cmdWr & cmd.countDown & (i == `RSA_GPR_COUNT)) begin
					gpr[i] <= gpr[i] - `RSA_STEP_BYTE;
				end else if (cmdWr & cmd.stepSource & (i == `RSA_GPR_SRC)) begin
					gpr[i] <= step(gpr[i], cmd.stepDown, cmd.wordStep);
				end else if (cmdWr & cmd.stepDest & (i == `RSA_GPR_DEST)) begin
					gpr[i] <= step(gpr[i], cmd.stepDown, cmd.wordStep);
				end
			end
		end
	end

	// segment bases
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			for (int s = 0; s < `RSA_NUM_SEG; s++) begin
				segBase[s] <= `RSA_RST_WORD;
			end
		end else begin
			for (int s = 0; s < `RSA_NUM_SEG; s++) begin
				if (wrAcc & segHit & (segSelBus == 2'(s))) begin
					segBase[s] <= merge(segBase[s], writedata[15:0], wordBe);
				end
			end
		end
	end

	// control registers and displacement
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			fetchPointer <= `RSA_RST_WORD;
			flags <= `RSA_RST_WORD;
			dispReg <= `RSA_RST_WORD;
		end else begin
			if (wrAcc & fetchHit) begin
				fetchPointer <= merge(fetchPointer, writedata[15:0], wordBe);
			end else if (cmdWr & isFetch) begin
				fetchPointer <= fetchPointer + `RSA_STEP_BYTE;
			end
			if (flagUpd.load) begin
				flags <= flagUpd.value;
			end else if (wrAcc & flagHit) begin
				flags <= merge(flags, writedata[15:0], wordBe);
			end
			if (wrAcc & dispHit) begin
				dispReg <= merge(dispReg, writedata[15:0], wordBe);
			end
		end
	end

	// checks
	sequence s_req_wait;
		busReq & waitrequest;
	endsequence
	sequence s_answer;
		!waitrequest ##1 waitrequest;
	endsequence
	property p_bus_answer;
		s_req_wait |=> s_answer;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("no one-cycle bus answer");

	property p_phys_sum;
		cmdWr |=> physAddr == 20'(({$past(segBase[segPick]), 4'h0}) + {4'h0, $past(logicalAddr)});
	endproperty
	a_phys_sum: assert property (p_phys_sum) else $error("physical address sum wrong");

	property p_valid_pulse;
		cmdWr |=> physValid ##1 !physValid;
	endproperty
	a_valid_pulse: assert property (p_valid_pulse) else $error("address valid not one cycle");

	property p_fetch_step;
		cmdWr & isFetch |=> fetchPointer == $past(fetchPointer) + `RSA_STEP_BYTE
			&& physAddr == 20'({$past(segBase[`RSA_SEG_CS]), 4'h0} + {4'h0, $past(fetchPointer)});
	endproperty
	a_fetch_step: assert property (p_fetch_step) else $error("fetch address or step wrong");

	property p_stack_addr;
		cmdWr & isStack |=> physAddr == 20'({$past(segBase[`RSA_SEG_SS]), 4'h0}
			+ {4'h0, $past(gpr[`RSA_GPR_STACK])});
	endproperty
	a_stack_addr: assert property (p_stack_addr) else $error("stack address wrong");

	property p_count_down;
		cmdWr & cmd.countDown |=> gpr[`RSA_GPR_COUNT] == $past(gpr[`RSA_GPR_COUNT]) - `RSA_STEP_BYTE;
	endproperty
	a_count_down: assert property (p_count_down) else $error("count not decremented");

	property p_source_step;
		cmdWr & cmd.stepSource & !cmd.stepDown & cmd.wordStep
			|=> gpr[`RSA_GPR_SRC] == $past(gpr[`RSA_GPR_SRC]) + `RSA_STEP_WORD;
	endproperty
	a_source_step: assert property (p_source_step) else $error("source index step wrong");

	property p_dest_down;
		cmdWr & cmd.stepDest & cmd.stepDown & !cmd.wordStep
			|=> gpr[`RSA_GPR_DEST] == $past(gpr[`RSA_GPR_DEST]) - `RSA_STEP_BYTE;
	endproperty
	a_dest_down: assert property (p_dest_down) else $error("dest index step wrong");

	property p_byte_keep;
		wrAcc & byteHit & byteenable[0] & !byteHigh
			|=> gpr[$past(byteReg)][15:8] == $past(gpr[{1'b0, byteReg}][15:8])
			&& gpr[$past(byteReg)][7:0] == $past(writedata[7:0]);
	endproperty
	a_byte_keep: assert property (p_byte_keep) else $error("byte write disturbed other half");

	property p_flag_load;
		flagUpd.load |=> flags == $past(flagUpd.value);
	endproperty
	a_flag_load: assert property (p_flag_load) else $error("flags not loaded");

	property p_read_word;
		read & waitrequest & gprHit |=> readdata == {16'h0000, $past(gpr[gprSel])} && !waitrequest;
	endproperty
	a_read_word: assert property (p_read_word) else $error("register read wrong");

	property p_word_write;
		wrAcc & gprHit & (wordBe == 2'h3) |=> gpr[$past(gprSel)] == $past(writedata[15:0]);
	endproperty
	a_word_write: assert property (p_word_write) else $error("register write lost");

	property p_seg_write;
		wrAcc & segHit & (wordBe == 2'h3) |=> segBase[$past(segSelBus)] == $past(writedata[15:0]);
	endproperty
	a_seg_write: assert property (p_seg_write) else $error("segment base write lost");

	property p_byte_high;
		wrAcc & byteHit & byteenable[0] & byteHigh
			|=> gpr[$past(byteReg)] == {$past(writedata[7:0]), $past(byteWord[7:0])};
	endproperty
	a_byte_high: assert property (p_byte_high) else $error("high byte write wrong");

	property p_read_byte;
		read & waitrequest & byteHit |=> readdata == {24'h00_0000, $past(byteRead)};
	endproperty
	a_read_byte: assert property (p_read_byte) else $error("byte read wrong");

	property p_read_seg;
		read & waitrequest & segHit |=> readdata == {16'h0000, $past(segBase[segSelBus])};
	endproperty
	a_read_seg: assert property (p_read_seg) else $error("segment base read wrong");

	property p_read_fetch;
		read & waitrequest & fetchHit |=> readdata == {16'h0000, $past(fetchPointer)};
	endproperty
	a_read_fetch: assert property (p_read_fetch) else $error("fetch pointer read wrong");

	property p_read_phys;
		read & waitrequest & physHit |=> readdata == {12'h000, $past(physAddr)};
	endproperty
	a_read_phys: assert property (p_read_phys) else $error("physical address read wrong");

	property p_read_unmapped;
		read & waitrequest & !(gprHit | segHit | byteHit | fetchHit | flagHit | dispHit | physHit)
			|=> readdata == `RSA_RST_DATA;
	endproperty
	a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read not zero");

	property p_ip_write;
		wrAcc & fetchHit & (wordBe == 2'h3) |=> fetchPointer == $past(writedata[15:0]);
	endproperty
	a_ip_write: assert property (p_ip_write) else $error("fetch pointer write lost");

	property p_ip_hold;
		!cmdWr & !(wrAcc & fetchHit) |=> $stable(fetchPointer);
	endproperty
	a_ip_hold: assert property (p_ip_hold) else $error("fetch pointer moved");

	property p_stack_keep;
		cmdWr |=> $stable(gpr[`RSA_GPR_STACK]) && $stable(gpr[`RSA_GPR_FRAME]);
	endproperty
	a_stack_keep: assert property (p_stack_keep) else $error("stack pointers moved");

	property p_phys_hold;
		!cmdWr |=> $stable(physAddr);
	endproperty
	a_phys_hold: assert property (p_phys_hold) else $error("physical address moved");

	property p_valid_only_cmd;
		!cmdWr |=> !physValid;
	endproperty
	a_valid_only_cmd: assert property (p_valid_only_cmd) else $error("stray address valid");

	property p_direct_addr;
		cmdWr & !isFetch & !isStack & !isExtra & cmd.useDisp & !cmd.useBase & !cmd.useIndex
			|=> physAddr == 20'({$past(segBase[`RSA_SEG_DS]), 4'h0} + {4'h0, $past(dispReg)});
	endproperty
	a_direct_addr: assert property (p_direct_addr) else $error("direct data address wrong");

	property p_full_sum;
		cmdWr & isExtra & cmd.useDisp & cmd.useBase & cmd.baseIsFrame & cmd.useIndex & cmd.indexIsDest
			|=> physAddr == 20'({$past(segBase[`RSA_SEG_ES]), 4'h0}
			+ {4'h0, 16'($past(dispReg) + $past(gpr[`RSA_GPR_FRAME]) + $past(gpr[`RSA_GPR_DEST]))});
	endproperty
	a_full_sum: assert property (p_full_sum) else $error("based indexed address wrong");

	property p_source_down;
		cmdWr & cmd.stepSource & cmd.stepDown & cmd.wordStep
			|=> gpr[`RSA_GPR_SRC] == $past(gpr[`RSA_GPR_SRC]) - `RSA_STEP_WORD;
	endproperty
	a_source_down: assert property (p_source_down) else $error("source index down step wrong");

	property p_dest_up;
		cmdWr & cmd.stepDest & !cmd.stepDown & !cmd.wordStep
			|=> gpr[`RSA_GPR_DEST] == $past(gpr[`RSA_GPR_DEST]) + `RSA_STEP_BYTE;
	endproperty
	a_dest_up: assert property (p_dest_up) else $error("dest index up step wrong");

	property p_disp_write;
		wrAcc & dispHit & (wordBe == 2'h3) |=> dispReg == $past(writedata[15:0]);
	endproperty
	a_disp_write: assert property (p_disp_write) else $error("displacement write lost");

	property p_flag_write;
		!flagUpd.load & wrAcc & flagHit & (wordBe == 2'h3) |=> flags == $past(writedata[15:0]);
	endproperty
	a_flag_write: assert property (p_flag_write) else $error("flag write lost");

	property p_count_hold;
		cmdWr & !cmd.countDown |=> $stable(gpr[`RSA_GPR_COUNT]);
	endproperty
	a_count_hold: assert property (p_count_hold) else $error("count moved without request");
endmodule : rsa_register_set

// [tb/rsa_flag_source.sv]
// execution unit stand-in driving flag updates
`timescale 1ns/1ps
module rsa_flag_source (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// command from bench
	input wire logic fire,
	input wire logic [15:0] fireVal,
	// flag update port
	output rsa_pkg::rsa_flag_upd_s flagUpd
);
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			flagUpd <= '0;
		end else if (fire) begin
			flagUpd <= {1'b1, fireVal};
		end else begin
			// no stale value between updates
			flagUpd <= {1'b0, ~flagUpd.value};
		end
	end
endmodule : rsa_flag_source

// [tb/rsa_register_set_tb_top.sv]
// self-checking bench for the register set and address generator
`timescale 1ns/1ps
module rsa_register_set_tb_top;
	logic ref_clk, reset, read, write, fire, waitrequest, physValid, pv;
	logic [7:0] address;
	logic [31:0] writedata, readdata, rd, seed;
	logic [3:0] byteenable;
	logic [15:0] fireVal, d, b, x;
	logic [15:0] v [8];
	logic [15:0] s [4];
	logic [11:0] c;
	rsa_pkg::rsa_flag_upd_s flagUpd;
	rsa_pkg::rsa_phys_t physAddr, pa;
	int err_count, cmp_count;
	rsa_register_set i_dut (.ref_clk(ref_clk), .reset(reset), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .flagUpd(flagUpd), .physAddr(physAddr), .physValid(physValid));
	rsa_flag_source i_exec (.ref_clk(ref_clk), .reset(reset), .fire(fire), .fireVal(fireVal),
		.flagUpd(flagUpd));
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk
	// one transfer; ends one rising edge after acceptance
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] be);
		read <= !wr;
		write <= wr;
		address <= a;
		writedata <= wd;
		byteenable <= be;
		do begin
			@(posedge ref_clk);
		end while (waitrequest !== 1'b0);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		// address valid stands only in the cycle after acceptance
		@(negedge ref_clk);
		pv = physValid;
		pa = physAddr;
		@(posedge ref_clk);
	endtask : bus
	function automatic logic [19:0] ph(input logic [15:0] sg, input logic [15:0] o);
		return {sg, 4'h0} + {4'h0, o};
	endfunction : ph
	task cmd(input logic [11:0] cw, input logic [19:0] e);
		bus(1, 8'h40, {20'h0, cw}, 4'hF);
		chk(pv, 1);
		chk(pa, e);
	endtask : cmd
	task stop_test;
		$display("counts: %0d compares, %0d mismatches", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test
	initial begin
		// about ninety transfers of three cycles each, with wide margin
		#40000;
		err_count++;
		stop_test();
	end
	initial begin
		seed = 32'h2276;
		reset = 1'b1;
		{read, write, fire, address, writedata, byteenable, fireVal} = '0;
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		for (int i = 0; i < 8; i++) begin
			v[i] = 16'($random(seed));
			bus(1, 8'(i * 4), {16'($random(seed)), v[i]}, 4'hF);
		end
		for (int i = 0; i < 4; i++) begin
			s[i] = 16'($random(seed));
			bus(1, 8'(8'h30 + i * 4), {16'h0, s[i]}, 4'hF);
		end
		for (int i = 0; i < 8; i++) begin
			bus(0, 8'(i * 4), 0, 4'hF);
			chk(rd, {16'h0, v[i]});
		end
		for (int i = 0; i < 4; i++) begin
			bus(0, 8'(8'h30 + i * 4), 0, 4'hF);
			chk(rd, {16'h0, s[i]});
		end
		$display("test words done");
		bus(1, 8'h30, 32'h0000_FFFF, 4'hF);
		bus(1, 8'h20, 32'h0000_0010, 4'hF);
		cmd(12'h000, ph(16'hFFFF, 16'h0010));
		bus(0, 8'h20, 0, 4'hF);
		chk(rd, 32'h0000_0011);
		cmd(12'h001, ph(s[1], v[4]));
		bus(0, 8'h10, 0, 4'hF);
		chk(rd, {16'h0, v[4]});
		d = 16'($random(seed));
		bus(1, 8'h44, {16'h0, d}, 4'hF);
		cmd(12'h042, ph(s[2], d));
		cmd(12'hED6, ph(s[2], d + v[3] + v[6]));
		bus(0, 8'h18, 0, 4'hF);
		chk(rd, {16'h0, v[6] - 16'h0002});
		bus(0, 8'h04, 0, 4'hF);
		chk(rd, {16'h0, v[1] - 16'h0001});
		v[6] = v[6] - 16'h0002;
		v[1] = v[1] - 16'h0001;
		cmd(12'h17F, ph(s[3], d + v[5] + v[7]));
		bus(0, 8'h1C, 0, 4'hF);
		chk(rd, {16'h0, v[7] + 16'h0001});
		v[7] = v[7] + 16'h0001;
		cmd(12'h8C2, ph(s[2], d));
		cmd(12'h342, ph(s[2], d));
		bus(0, 8'h18, 0, 4'hF);
		chk(rd, {16'h0, v[6] + 16'h0002});
		bus(0, 8'h1C, 0, 4'hF);
		chk(rd, {16'h0, v[7] - 16'h0001});
		v[6] = v[6] + 16'h0002;
		v[7] = v[7] - 16'h0001;
		bus(0, 8'h48, 0, 4'hF);
		chk(rd, {12'h000, ph(s[2], d)});
		bus(0, 8'h44, 0, 4'hF);
		chk(rd, {16'h0, d});
		bus(0, 8'h40, 0, 4'hF);
		chk(rd, 32'h0000_0000);
		for (int j = 0; j < 16; j++) begin
			c = 12'h042 | (12'($random(seed)) & 12'h03F);
			b = c[2] ? (c[3] ? v[5] : v[3]) : 16'h0;
			x = c[4] ? (c[5] ? v[7] : v[6]) : 16'h0;
			cmd(c, ph(s[c[1:0]], d + b + x));
		end
		$display("test address done");
		fire <= 1'b1;
		fireVal <= 16'($random(seed));
		@(posedge ref_clk);
		fire <= 1'b0;
		repeat (3) @(posedge ref_clk);
		bus(0, 8'h24, 0, 4'hF);
		chk(rd, {16'h0, fireVal});
		bus(1, 8'h24, {16'h0, d}, 4'hF);
		bus(0, 8'h24, 0, 4'hF);
		chk(rd, {16'h0, d});
		for (int i = 0; i < 4; i++) begin
			b = 16'($random(seed));
			bus(1, 8'(8'h60 + i * 4), {24'h0, b[7:0]}, 4'h1);
			bus(0, 8'(i * 4), 0, 4'hF);
			chk(rd, {16'h0, v[i][15:8], b[7:0]});
			bus(1, 8'(8'h70 + i * 4), {24'h0, b[15:8]}, 4'h1);
			bus(0, 8'(i * 4), 0, 4'hF);
			chk(rd, {16'h0, b});
			bus(0, 8'(8'h70 + i * 4), 0, 4'hF);
			chk(rd, {24'h0, b[15:8]});
		end
		bus(1, 8'h50, 32'h0000_ABCD, 4'hF);
		bus(0, 8'h50, 0, 4'hF);
		chk(rd, 32'h0000_0000);
		bus(0, 8'h02, 0, 4'hF);
		chk(rd, 32'h0000_0000);
		$display("test bytes done");
		stop_test();
	end
endmodule : rsa_register_set_tb_top
